// File: hw/mdx_io_assign.sv
module mdx_io_assign (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // direct input terminals (pins)
  input wire logic [mdx_pkg::DIN_N-1:0] direct_input_terminal_in,
  // remote input slots, written by the serial link handler
  input wire logic [mdx_pkg::SLOT_N-1:0] remote_input_slot_in,
  // assignment tables and drive status
  input mdx_pkg::mdx_cfg_t cfg_in,
  input mdx_pkg::mdx_stat_t stat_in,
  // direct output terminals (pins)
  output logic [mdx_pkg::DOUT_N-1:0] direct_output_terminal_out,
  // remote output slots, read by the serial link handler
  output logic [mdx_pkg::SLOT_N-1:0] remote_output_slot_out,
  // routed input functions for the rest of the drive
  output logic [mdx_pkg::FN_N-1:0] input_func_out,
  // excitation and motion control
  output logic excite_out,
  output logic brake_release_out,
  output logic ready_out,
  output logic deviation_clear_out,
  output logic immediate_stop_out,
  output logic in_position_out
);
  import mdx_pkg::*;

  // state of the block, apart from the excitation sequencer's own register
  typedef struct packed {
    logic [DIN_N-1:0] din_s1;
    logic [DIN_N-1:0] din_s2;
    mdx_cfg_t cfg_stage;
    mdx_cfg_t cfg;
    logic [FN_N-1:0] fn;
    mdx_drv_t drv;
    logic [DOUT_N-1:0] dout;
    logic [SLOT_N-1:0] rout;
    logic dev_clr;
    logic stop_now;
    logic in_pos;
  } mdx_state_t;

  mdx_state_t st_ff;
  mdx_state_t nxt_st;

  // combinational routing results
  logic [FN_N-1:0] dir_act;
  logic [FN_N-1:0] dir_asg;
  logic [FN_N-1:0] rem_act;
  logic [FN_N-1:0] rem_asg;
  logic [FN_N-1:0] fn_or;
  logic hmi_val;
  logic [FN_N-1:0] out_src;
  mdx_drv_t ex_drv;

  // one-hot decode of a function code
  function automatic logic [FN_N-1:0] fn_dec(input mdx_fn_t code);
    logic [FN_N-1:0] v;
    v = '0;
    v[code] = 1'b1;
    return v;
  endfunction

  // pick one status bit by output function code
  function automatic logic fn_pick(input logic [FN_N-1:0] src, input mdx_fn_t code);
    return src[code];
  endfunction

  // direct terminals: sources active and functions assigned
  always_comb begin
    dir_act = '0;
    dir_asg = '0;
    for (int i = 0; i < DIN_N; i++) begin
      dir_asg = dir_asg | fn_dec(st_ff.cfg.din[i]);
      if (st_ff.din_s2[i]) begin
        dir_act = dir_act | fn_dec(st_ff.cfg.din[i]);
      end
    end
  end

  // remote slots: sources active and functions assigned
  always_comb begin
    rem_act = '0;
    rem_asg = '0;
    for (int s = 0; s < SLOT_N; s++) begin
      rem_asg = rem_asg | fn_dec(st_ff.cfg.rin[s]);
      if (remote_input_slot_in[s]) begin
        rem_act = rem_act | fn_dec(st_ff.cfg.rin[s]);
      end
    end
  end

  // panel interlock combines its sources differently
  always_comb begin
    if (!dir_asg[FI_HMI] && !rem_asg[FI_HMI]) begin
      hmi_val = 1'b1;
    end else if (dir_asg[FI_HMI] && rem_asg[FI_HMI]) begin
      hmi_val = dir_act[FI_HMI] && rem_act[FI_HMI];
    end else begin
      hmi_val = dir_act[FI_HMI] || rem_act[FI_HMI];
    end
  end

  // merged input functions
  always_comb begin
    fn_or = dir_act | rem_act;
    fn_or[FI_HMI] = hmi_val;
    fn_or[FI_NONE] = 1'b0; // unused code carries nothing
  end

  // status bits an output function may select
  always_comb begin
    out_src = stat_in.misc;
    for (int s = 0; s < SLOT_N; s++) begin
      out_src[FO_MISC_BASE + mdx_fn_t'(s)] = stat_in.misc[s];
    end
    out_src[FO_CONST_OFF] = 1'b0;
    out_src[FO_SERVO_ON_MONITOR] = st_ff.drv.excite;
    out_src[FO_READY] = st_ff.drv.ready;
    out_src[FO_ALM_NO] = stat_in.alarm;
    out_src[FO_ALM_NC] = !stat_in.alarm; // closed while healthy
    out_src[FO_IN_POS] = st_ff.in_pos;
    out_src[FO_MOVE] = stat_in.moving;
    out_src[FO_COMMUNICATION_POWER_STATUS] = stat_in.comm_power;
    out_src[FO_USER_OUTPUT_0] = stat_in.user_out[0];
    out_src[FO_USR_OUT1] = stat_in.user_out[1];
    out_src[FO_STOP_ST] = st_ff.fn[FI_STOP];
    out_src[FO_FREE_ST] = st_ff.fn[FI_FREE];
  end

  // excitation sequencer
  mdx_excite mdx_excite_i (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .servo_on_in(st_ff.fn[FI_SON]),
    .free_run_in(st_ff.fn[FI_FREE]),
    .dev_clear_in(st_ff.fn[FI_CLR]),
    .drv_out(ex_drv)
  );

  // next state
  always_comb begin
    nxt_st = st_ff;
    // pin synchroniser
    nxt_st.din_s1 = direct_input_terminal_in;
    nxt_st.din_s2 = st_ff.din_s1;
    // tables take effect only once stable for a cycle
    nxt_st.cfg_stage = cfg_in;
    if (cfg_in == st_ff.cfg_stage) begin
      nxt_st.cfg = st_ff.cfg_stage;
    end
    nxt_st.fn = fn_or;
    nxt_st.drv = ex_drv;
    // deviation clear and immediate stop
    nxt_st.dev_clr = st_ff.fn[FI_CLR];
    nxt_st.stop_now = st_ff.fn[FI_CLR] && stat_in.moving;
    // in-position only from drive status, never from stop inputs
    nxt_st.in_pos = stat_in.in_position;
    // output terminals and slots
    for (int i = 0; i < DOUT_N; i++) begin
      nxt_st.dout[i] = fn_pick(out_src, st_ff.cfg.dout[i]);
    end
    for (int s = 0; s < SLOT_N; s++) begin
      nxt_st.rout[s] = fn_pick(out_src, st_ff.cfg.rout[s]);
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_ff <= '{din_s1: '0, din_s2: '0, cfg_stage: CFG_RST, cfg: CFG_RST, fn: '0,
                 drv: '0, dout: '0, rout: '0, dev_clr: 1'b0, stop_now: 1'b0, in_pos: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign direct_output_terminal_out = st_ff.dout;
  assign remote_output_slot_out = st_ff.rout;
  assign input_func_out = st_ff.fn;
  assign excite_out = st_ff.drv.excite;
  assign brake_release_out = st_ff.drv.brake_release;
  assign ready_out = st_ff.drv.ready;
  assign deviation_clear_out = st_ff.dev_clr;
  assign immediate_stop_out = st_ff.stop_now;
  assign in_position_out = st_ff.in_pos;
endmodule // mdx_io_assign

// File: pkg/mdx_pkg.sv
// Contract
// - Four direct input terminals each carry the input function set by their own code.
// - A function mapped to several sources acts when any of those sources is on.
// - The panel interlock reads as on while no terminal or slot carries it.
// - The panel interlock mapped on both a terminal and a slot acts only when both are on.
// - Two direct output terminals each drive the output function set by their own code.
// - Remote slots are written and read only by the serial link handler.
// - Thirty-two remote input slots each carry the function set by their own code.
// - Thirty-two remote output slots each drive the function set by their own code.
// - Servo-on excites the motor, then releases the brake and raises ready.
// - Servo-off drops ready first, then de-excites and engages the brake.
// - Free-run on an excited motor drops ready, de-excites and releases the brake.
// - Free-run off after freeing re-excites the motor, then raises ready.
// - With the motor not excited, free-run releases the brake and its release engages it.
// - A stop input never forces the in-position output on.
// - Deviation clear zeroes the deviation counter and stops a moving motor at once.
// - Deviation clear going off raises ready again.
package mdx_pkg;
  localparam int FN_W = 6;
  localparam int FN_N = 64;
  localparam int DIN_N = 4;
  localparam int DOUT_N = 2;
  localparam int SLOT_N = 32;

  typedef logic [FN_W-1:0] mdx_fn_t;

  // input function codes
  localparam mdx_fn_t FI_NONE = 6'h00;
  localparam mdx_fn_t FI_SON = 6'h01;
  localparam mdx_fn_t FI_FREE = 6'h02;
  localparam mdx_fn_t FI_STOP = 6'h03;
  localparam mdx_fn_t FI_QUICK_STOP_INPUT = 6'h04;
  localparam mdx_fn_t FI_CLR = 6'h05;
  localparam mdx_fn_t FI_ALARM_RESET_INPUT = 6'h06;
  localparam mdx_fn_t FI_HMI = 6'h07;
  localparam mdx_fn_t FI_UNIT_ID_SELECT_BIT0 = 6'h08;
  localparam mdx_fn_t FI_UNIT_ID_SELECT_BIT1 = 6'h09;
  localparam mdx_fn_t FI_PLOOP = 6'h0a;
  localparam mdx_fn_t FI_TRQ_LMT = 6'h0b;
  localparam mdx_fn_t FI_FW_JOG = 6'h0c;
  localparam mdx_fn_t FI_RV_JOG = 6'h0d;
  localparam mdx_fn_t FI_FW_SPD = 6'h0e;
  localparam mdx_fn_t FI_RV_SPD = 6'h0f;
  localparam mdx_fn_t FI_DSEL_BASE = 6'h10;
  localparam mdx_fn_t FI_OPNUM_BASE = 6'h18;
  localparam mdx_fn_t FI_HOME = 6'h20;
  localparam mdx_fn_t FI_START = 6'h21;
  localparam mdx_fn_t FI_SSTART = 6'h22;

  // output function codes; codes from FO_MISC_BASE up pick misc status bits
  localparam mdx_fn_t FO_CONST_OFF = 6'h00;
  localparam mdx_fn_t FO_SERVO_ON_MONITOR = 6'h01;
  localparam mdx_fn_t FO_READY = 6'h02;
  localparam mdx_fn_t FO_ALM_NO = 6'h03;
  localparam mdx_fn_t FO_ALM_NC = 6'h04;
  localparam mdx_fn_t FO_IN_POS = 6'h05;
  localparam mdx_fn_t FO_MOVE = 6'h06;
  localparam mdx_fn_t FO_COMMUNICATION_POWER_STATUS = 6'h07;
  localparam mdx_fn_t FO_USER_OUTPUT_0 = 6'h08;
  localparam mdx_fn_t FO_USR_OUT1 = 6'h09;
  localparam mdx_fn_t FO_STOP_ST = 6'h0a;
  localparam mdx_fn_t FO_FREE_ST = 6'h0b;
  localparam mdx_fn_t FO_MISC_BASE = 6'h20;

  // assignment tables
  typedef struct packed {
    mdx_fn_t [DIN_N-1:0] din;
    mdx_fn_t [SLOT_N-1:0] rin;
    mdx_fn_t [DOUT_N-1:0] dout;
    mdx_fn_t [SLOT_N-1:0] rout;
  } mdx_cfg_t;

  // drive status feeding the output functions
  typedef struct packed {
    logic alarm;
    logic comm_power;
    logic in_position;
    logic moving;
    logic [1:0] user_out;
    logic [FN_N-1:0] misc;
  } mdx_stat_t;

  // excitation outputs
  typedef struct packed {
    logic excite;
    logic brake_release;
    logic ready;
  } mdx_drv_t;

  typedef enum logic [5:0] {
    EX_IDLE = 6'h01,
    EX_IDLE_FREE = 6'h02,
    EX_ENERGIZE = 6'h04,
    EX_READY = 6'h08,
    EX_DROP = 6'h10,
    EX_FREED = 6'h20
  } mdx_ex_st_t;

  // factory table of the remote input slots
  function automatic mdx_fn_t rin_default(input int s);
    case (s)
      0: return FI_SON;
      1: return FI_PLOOP;
      2: return FI_TRQ_LMT;
      3: return FI_CLR;
      4: return FI_QUICK_STOP_INPUT;
      5: return FI_STOP;
      6: return FI_FREE;
      7: return FI_ALARM_RESET_INPUT;
      16: return FI_FW_JOG;
      17: return FI_RV_JOG;
      18: return FI_FW_SPD;
      19: return FI_RV_SPD;
      20: return FI_HOME;
      21: return FI_NONE;
      22: return FI_START;
      23: return FI_SSTART;
      default: return (s < 16) ? FI_DSEL_BASE + mdx_fn_t'(s - 8) : FI_OPNUM_BASE + mdx_fn_t'(s - 24);
    endcase
  endfunction

  // factory table of the remote output slots
  function automatic mdx_fn_t rout_default(input int s);
    case (s)
      0: return FO_SERVO_ON_MONITOR;
      7: return FO_ALM_NO;
      9: return FO_IN_POS;
      13: return FO_MOVE;
      26, 27, 28, 29: return FO_CONST_OFF;
      30: return FO_USER_OUTPUT_0;
      31: return FO_USR_OUT1;
      default: return FO_MISC_BASE + mdx_fn_t'(s);
    endcase
  endfunction

  function automatic mdx_cfg_t cfg_default();
    mdx_cfg_t c;
    c.din = {FI_FREE, FI_STOP, FI_UNIT_ID_SELECT_BIT1, FI_UNIT_ID_SELECT_BIT0};
    c.dout = {FO_ALM_NC, FO_COMMUNICATION_POWER_STATUS};
    for (int s = 0; s < SLOT_N; s++) begin
      c.rin[s] = rin_default(s);
      c.rout[s] = rout_default(s);
    end
    return c;
  endfunction

  localparam mdx_cfg_t CFG_RST = cfg_default();
endpackage

// File: hw/mdx_excite.sv
module mdx_excite (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // routed input functions
  input wire logic servo_on_in,
  input wire logic free_run_in,
  input wire logic dev_clear_in,
  // excitation outputs
  output mdx_pkg::mdx_drv_t drv_out
);
  import mdx_pkg::*;

  typedef struct packed {
    mdx_ex_st_t st;
    mdx_drv_t drv;
  } mdx_ex_state_t;

  mdx_ex_state_t ex_ff;
  mdx_ex_state_t nxt_ex;

  // excitation sequencing
  always_comb begin
    nxt_ex = ex_ff;
    unique case (ex_ff.st)
      EX_IDLE: begin
        if (free_run_in) begin
          nxt_ex.st = EX_IDLE_FREE;
        end else if (servo_on_in) begin
          nxt_ex.st = EX_ENERGIZE;
        end
      end
      EX_IDLE_FREE: begin
        if (!free_run_in) begin
          nxt_ex.st = EX_IDLE;
        end
      end
      EX_ENERGIZE: begin
        if (!servo_on_in) begin
          nxt_ex.st = EX_IDLE;
        end else if (free_run_in) begin
          nxt_ex.st = EX_FREED;
        end else begin
          nxt_ex.st = EX_READY;
        end
      end
      EX_READY: begin
        if (!servo_on_in) begin
          nxt_ex.st = EX_DROP;
        end else if (free_run_in) begin
          nxt_ex.st = EX_FREED;
        end
      end
      EX_DROP: nxt_ex.st = EX_IDLE;
      EX_FREED: begin
        if (!servo_on_in) begin
          nxt_ex.st = free_run_in ? EX_IDLE_FREE : EX_IDLE;
        end else if (!free_run_in) begin
          nxt_ex.st = EX_ENERGIZE;
        end
      end
      default: nxt_ex.st = EX_IDLE;
    endcase
    // outputs follow the next state so they stay registered
    nxt_ex.drv.excite = (nxt_ex.st == EX_ENERGIZE) || (nxt_ex.st == EX_READY) || (nxt_ex.st == EX_DROP);
    nxt_ex.drv.brake_release = (nxt_ex.st == EX_READY) || (nxt_ex.st == EX_DROP) ||
                               (nxt_ex.st == EX_FREED) || (nxt_ex.st == EX_IDLE_FREE);
    nxt_ex.drv.ready = (nxt_ex.st == EX_READY) && !dev_clear_in;
  end

  // state register
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ex_ff <= '{st: EX_IDLE, drv: '0};
    end else begin
      ex_ff <= nxt_ex;
    end
  end

  assign drv_out = ex_ff.drv;
endmodule // mdx_excite

// File: verification/mdx_io_assign_props.sv
module mdx_io_assign_props (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // watched ports
  input mdx_pkg::mdx_stat_t stat_in,
  input wire logic [mdx_pkg::FN_N-1:0] input_func_out,
  input wire logic excite_out,
  input wire logic brake_release_out,
  input wire logic ready_out,
  input wire logic deviation_clear_out,
  input wire logic immediate_stop_out,
  input wire logic in_position_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import mdx_pkg::*;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // routing and motion status
  a_null_code_off:
    assert property (!input_func_out[FI_NONE]) else $error("unused code active");
  a_inpos_no_stop:
    assert property (in_position_out |-> $past(stat_in.in_position)) else $error("in-position without cause");
  a_clear_follows:
    assert property (deviation_clear_out == $past(input_func_out[FI_CLR])) else $error("clear not following");
  a_stop_on_clear:
    assert property (immediate_stop_out == ($past(input_func_out[FI_CLR]) && $past(stat_in.moving)))
      else $error("stop not matching clear while moving");

  // excitation sequencing
  a_ready_cause:
    assert property (ready_out |-> excite_out && brake_release_out && !$past(input_func_out[FI_CLR], 2))
      else $error("ready without cause");
  a_brake_after_ex:
    assert property ($rose(brake_release_out) && excite_out |-> $past(excite_out)) else $error("brake freed early");
  a_ready_first:
    assert property ($fell(excite_out) && !brake_release_out |-> !$past(ready_out)) else $error("ready still up");
  a_free_release:
    assert property (excite_out && input_func_out[FI_SON] && $past(input_func_out[FI_SON])
      && $rose(input_func_out[FI_FREE]) |-> ##2 !excite_out && brake_release_out && !ready_out)
      else $error("free-run not freeing");

  // main scenarios reached
  c_ready: cover property ($rose(ready_out));
  c_freed: cover property (!excite_out && brake_release_out);
  c_stop: cover property (immediate_stop_out);
endmodule // mdx_io_assign_props

// File: verification/mdx_host.sv
module mdx_host (
  // clock
  input wire logic clk_in,
  // levels commanded by the sequence, and remote output slots read back
  input wire logic [mdx_pkg::DIN_N-1:0] pin_cmd_in,
  input wire logic [mdx_pkg::SLOT_N-1:0] slot_cmd_in,
  input wire logic [mdx_pkg::SLOT_N-1:0] slot_rd_in,
  // wired and serial lines
  output logic [mdx_pkg::DIN_N-1:0] pin_out,
  output logic [mdx_pkg::SLOT_N-1:0] slot_out,
  output logic [mdx_pkg::SLOT_N-1:0] slot_seen_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import mdx_pkg::*;
  // pin and slot command lines idle low until the first update
  initial begin
    pin_out = '0;
    slot_out = '0;
  end
  // host updates just after the falling edge
  always @(negedge clk_in) begin
    pin_out <= pin_cmd_in;
    slot_out <= slot_cmd_in;
    slot_seen_out <= slot_rd_in;
  end
endmodule // mdx_host

// File: verification/mdx_io_assign_bench.sv
module mdx_io_assign_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mdx_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [DIN_N-1:0] pin_cmd = '0;
  logic [DIN_N-1:0] din;
  logic [SLOT_N-1:0] slot_cmd = '0;
  logic [SLOT_N-1:0] rin, rout, rseen;
  mdx_cfg_t cfg = CFG_RST;
  mdx_stat_t stat = '0;
  logic [DOUT_N-1:0] dout;
  logic [FN_N-1:0] fn;
  logic exc, brk, rdy, dclr, istop, inpos;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  // son, free, clr, then expected excite, brake released, ready
  logic [5:0] steps[$] = '{6'h27, 6'h2e, 6'h27, 6'h32, 6'h27, 6'h00, 6'h12, 6'h00};

  mdx_host mdx_host_i (.clk_in(clk_in), .pin_cmd_in(pin_cmd), .slot_cmd_in(slot_cmd), .slot_rd_in(rout),
    .pin_out(din), .slot_out(rin), .slot_seen_out(rseen));
  mdx_io_assign mdx_io_assign_i (.clk_in(clk_in), .nrst_in(nrst_in), .direct_input_terminal_in(din),
    .remote_input_slot_in(rin), .cfg_in(cfg), .stat_in(stat), .direct_output_terminal_out(dout),
    .remote_output_slot_out(rout), .input_func_out(fn), .excite_out(exc), .brake_release_out(brk),
    .ready_out(rdy), .deviation_clear_out(dclr), .immediate_stop_out(istop), .in_position_out(inpos));

  // clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // runaway guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(string what, logic [FN_N-1:0] exp, logic [FN_N-1:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected function vector from pins, slots and table
  function automatic logic [FN_N-1:0] fn_model(logic [DIN_N-1:0] d, logic [SLOT_N-1:0] r, mdx_cfg_t c);
    logic [FN_N-1:0] f = '0;
    logic hp = 0, hr = 0, vp = 0, vr = 0;
    for (int i = 0; i < DIN_N; i++) begin
      f[c.din[i]] |= d[i];
      if (c.din[i] == FI_HMI) begin
        hp = 1;
        vp |= d[i];
      end
    end
    for (int i = 0; i < SLOT_N; i++) begin
      f[c.rin[i]] |= r[i];
      if (c.rin[i] == FI_HMI) begin
        hr = 1;
        vr |= r[i];
      end
    end
    f[FI_HMI] = (hp && hr) ? (vp && vr) : (!hp && !hr) ? 1'b1 : (vp || vr);
    f[FI_NONE] = 1'b0;
    return f;
  endfunction

  // expected level of one output function
  function automatic logic out_model(mdx_fn_t code, logic [FN_N-1:0] f, logic e, logic r);
    case (code)
      FO_CONST_OFF: return 1'b0;
      FO_SERVO_ON_MONITOR: return e;
      FO_READY: return r;
      FO_ALM_NO: return stat.alarm;
      FO_ALM_NC: return !stat.alarm;
      FO_IN_POS: return stat.in_position;
      FO_MOVE: return stat.moving;
      FO_COMMUNICATION_POWER_STATUS: return stat.comm_power;
      FO_USER_OUTPUT_0: return stat.user_out[0];
      FO_USR_OUT1: return stat.user_out[1];
      FO_STOP_ST: return f[FI_STOP];
      FO_FREE_ST: return f[FI_FREE];
      default: return (code >= FO_MISC_BASE) ? stat.misc[code - FO_MISC_BASE] : stat.misc[code];
    endcase
  endfunction

  // let everything settle, then compare every result
  task automatic check_all(logic e, logic b, logic r);
    logic [FN_N-1:0] f;
    logic [DOUT_N-1:0] ed;
    logic [SLOT_N-1:0] er;
    repeat (12) @(negedge clk_in);
    f = fn_model(pin_cmd, slot_cmd, cfg);
    for (int i = 0; i < DOUT_N; i++)
      ed[i] = out_model(cfg.dout[i], f, e, r);
    for (int i = 0; i < SLOT_N; i++)
      er[i] = out_model(cfg.rout[i], f, e, r);
    chk("input_func", f, fn);
    chk("direct_out", ed, dout);
    chk("remote_out", er, rout);
    chk("host_view", er, rseen);
    chk("drive", {e, b, r}, {exc, brk, rdy});
    chk("motion", {f[FI_CLR], f[FI_CLR] & stat.moving, stat.in_position}, {dclr, istop, inpos});
  endtask

  initial begin
    void'($urandom(37));
    repeat (20) @(negedge clk_in);
    chk("reset", '0, {exc, brk, rdy, dout, rout});
    nrst_in = 1'b1;
    // excitation walk on the factory table, free-run pin kept low
    foreach (steps[k]) begin
      stat = {6'($urandom), $urandom, $urandom};
      pin_cmd <= 4'($urandom) & 4'h7;
      slot_cmd <= ($urandom & ~32'h49) | {25'h0, steps[k][4], 2'h0, steps[k][3], 2'h0, steps[k][5]};
      check_all(steps[k][2], steps[k][1], steps[k][0]);
    end
    // interlock on a pin and a slot at once
    cfg.din[0] = FI_HMI;
    cfg.rin[21] = FI_HMI;
    for (int k = 0; k < 4; k++) begin
      pin_cmd <= 4'(k & 1);
      slot_cmd <= {10'h0, 1'(k >> 1), 21'h0};
      check_all(0, 0, 0);
    end
    // random tables and levels, excitation codes left out
    for (int n = 0; n < 12; n++) begin
      for (int i = 0; i < DIN_N; i++)
        cfg.din[i] = mdx_fn_t'(6 + $urandom % 29);
      for (int i = 0; i < SLOT_N; i++)
        cfg.rin[i] = mdx_fn_t'(6 + $urandom % 29);
      for (int i = 0; i < DOUT_N; i++)
        cfg.dout[i] = mdx_fn_t'($urandom);
      for (int i = 0; i < SLOT_N; i++)
        cfg.rout[i] = mdx_fn_t'($urandom);
      stat = {6'($urandom), $urandom, $urandom};
      pin_cmd <= 4'($urandom);
      slot_cmd <= $urandom;
      check_all(0, 0, 0);
    end
    // a table held for one cycle only must never apply
    stat.alarm = 1'b0;
    cfg.dout[0] = FO_CONST_OFF;
    check_all(0, 0, 0);
    cfg.dout[0] = FO_ALM_NC;
    @(negedge clk_in);
    cfg.dout[0] = FO_CONST_OFF;
    repeat (4) begin
      @(negedge clk_in);
      chk("flicker", '0, FN_N'(dout[0]));
    end
    // reset again in mid-run, then routing must come back from the held tables
    nrst_in = 1'b0;
    @(negedge clk_in);
    chk("reset_again", '0, {exc, brk, rdy, dout, rout});
    nrst_in = 1'b1;
    check_all(0, 0, 0);
    conclude();
  end
endmodule // mdx_io_assign_bench

bind mdx_io_assign mdx_io_assign_props mdx_io_assign_props_i (.clk_in, .nrst_in, .stat_in, .input_func_out,
  .excite_out, .brake_release_out, .ready_out, .deviation_clear_out, .immediate_stop_out, .in_position_out);
